// ===== sbir_pkg.sv
// Purpose: constants and types for the spi buffer and interrupt register block
// Assumes: 16-bit register port, byte addresses as printed
// Notes:   control bits not in the map are gathered at a chosen offset
`default_nettype none
package sbir_pkg;
  localparam logic [8:0]  SBIR_OFF_RXBUF  = 9'h14c;
  localparam logic [8:0]  SBIR_OFF_TXBUF  = 9'h14e;
  localparam logic [8:0]  SBIR_OFF_CTRL   = 9'h150;
  localparam logic [8:0]  SBIR_OFF_STAT   = 9'h152;
  localparam logic [8:0]  SBIR_OFF_IE     = 9'h15a;
  localparam logic [8:0]  SBIR_OFF_IFG    = 9'h15c;
  localparam logic [8:0]  SBIR_OFF_IV     = 9'h15e;
  localparam int          SBIR_BIT_RX     = 0;
  localparam int          SBIR_BIT_TX     = 1;
  localparam int          SBIR_BIT_SWRST  = 0;
  localparam int          SBIR_BIT_7BIT   = 1;
  localparam int          SBIR_BIT_OE     = 5;
  localparam int          SBIR_BIT_BUSY   = 0;
  localparam logic [1:0]  SBIR_IFG_RST    = 2'h2;
  localparam logic [1:0]  SBIR_CTRL_RST   = 2'h1;
  localparam logic [15:0] SBIR_IV_NONE    = 16'h0000;
  localparam logic [15:0] SBIR_IV_RX      = 16'h0002;
  localparam logic [15:0] SBIR_IV_TX      = 16'h0004;
  localparam int          SBIR_CHAR_BITS  = 8;

  typedef struct packed {
    logic [8:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } sbir_bus_req_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic ssel_n;
  } sbir_link_t;

  function automatic logic [7:0] sbir_mask7(input logic [7:0] d, input logic seven);
    sbir_mask7 = seven ? {1'b0, d[6:0]} : d;
  endfunction
endpackage
`default_nettype wire

// ===== sbir_shift.sv
// Purpose: spi slave shift engine, mode 0, msb first
// Assumes: synchronised sclk, mosi, ssel_n; sclk much slower than clock
// Notes:   miso driven from flops; 7-bit mode shifts seven bits
`default_nettype none
module sbir_shift
  import sbir_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire sbir_link_t link,
  input  wire logic       seven,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_take,
  output logic            rx_done,
  output logic      [7:0] rx_data,
  output logic            busy,
  output logic            miso
);
  logic       sclk_d_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic       act_r;
  wire        rise  = link.sclk & ~sclk_d_r & ~link.ssel_n;
  wire        fall  = ~link.sclk & sclk_d_r & ~link.ssel_n;
  wire  [3:0] nbits = seven ? 4'd7 : 4'd8;
  wire        start = ~act_r & ~link.ssel_n;
  wire  [7:0] sh_in = {sh_r[6:0], link.mosi};
  wire        last  = rise & (cnt_r + 4'd1 == nbits);
  assign tx_take = start & tx_valid;
  assign busy    = act_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      sclk_d_r <= 1'b0;
      sh_r     <= 8'h00;
      cnt_r    <= 4'h0;
      act_r    <= 1'b0;
      rx_done  <= 1'b0;
      rx_data  <= 8'h00;
      miso     <= 1'b0;
    end else begin
      sclk_d_r <= link.sclk;
      rx_done  <= last;
      if (link.ssel_n) begin
        act_r <= 1'b0;
        cnt_r <= 4'h0;
      end else if (start) begin
        // 7-bit data left-justified in shifter; top bit ignored
        act_r <= 1'b1;
        sh_r  <= seven ? {tx_data[6:0], 1'b0} : tx_data;
        miso  <= seven ? tx_data[6] : tx_data[7];
      end else if (rise) begin
        sh_r  <= sh_in;
        cnt_r <= last ? 4'h0 : cnt_r + 4'd1;
        if (last) begin
          rx_data <= seven ? {1'b0, sh_in[6:0]} : sh_in;
          act_r   <= 1'b0;
        end
      end else if (fall) begin
        miso <= sh_r[7];
      end
    end
  end
endmodule
`default_nettype wire

// ===== sbir_spi_master.sv
// Purpose: behavioural spi master facing the block pins
// Assumes: mode 0, msb first, 320 ns link period
// Notes:   sclk only runs inside a frame
`default_nettype none
module sbir_spi_master (
  output var logic sclk,
  output var logic mosi,
  output var logic ssel_n,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 160;
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ssel_n = 1'b1;
  end
  // long lead after select: slave loads its shift register via synchronisers
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    ssel_n = 1'b0;
    #(2*HALF);
    for (int i = n - 1; i >= 0; i--) begin
      mosi = tx[i];
      #HALF;
      sclk = 1'b1;
      rx[i] = miso;
      #HALF;
      sclk = 1'b0;
    end
    #HALF;
    ssel_n = 1'b1;
    // released line shows no stale data
    mosi = ~mosi;
  endtask
endmodule
`default_nettype wire

// ===== sbir_sync.sv
// Purpose: two-flop synchroniser for link pins
// Assumes: inputs are asynchronous to clock
// Notes:   first stage is read only by the second
`default_nettype none
module sbir_sync
  import sbir_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== sbir_top.sv
// Purpose: receive/transmit buffers and interrupt flag, enable and vector logic
// Assumes: software on a plain 16-bit register port, external spi master on pins
// Notes:   software reset bit holds buffers and flags at reset values
//
// Chosen here: strobed register access.
`default_nettype none
// Behaviour
// R1 - receive buffer holds last received character in bits 7-0, upper bits zero
// R2 - reading receive buffer clears receive flag and error flags
// R3 - seven-bit mode stores received characters right-aligned, top bit zero
// R4 - transmit buffer holds written byte until shifted; write clears transmit flag
// R5 - seven-bit mode ignores and clears top transmit bit
// R6 - transmit flag in bit 1 set while buffer empty; reset value 02h
// R7 - receive flag in bit 0 set on complete character; resets zero
// R8 - vector reads 000h none, 002h receive first, 004h transmit
// R9 - overrun set when new character arrives unread; cleared only by buffer read (code also clears it on software reset)
// R10 - interrupt output high while a flag and its enable are both set
module sbir_top
  import sbir_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [8:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        spi_sclk,
  input  wire logic        spi_mosi,
  input  wire logic        spi_ssel_n,
  output logic             spi_miso,
  output logic             irq
);
  logic [1:0] ctrl_r;
  logic [7:0] rxbuf_r;
  logic [7:0] txbuf_r;
  logic       tx_full_r;
  logic [1:0] ie_r;
  logic [1:0] ifg_r;
  logic       oe_r;
  logic       rx_unread_r;
  logic [2:0] pins_q;
  sbir_link_t link;
  logic       tx_take;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       busy;

  wire rst_all  = srst | ctrl_r[SBIR_BIT_SWRST];
  wire seven    = ctrl_r[SBIR_BIT_7BIT];
  wire wr_ctrl  = wr & (addr == SBIR_OFF_CTRL);
  wire wr_tx    = wr & (addr == SBIR_OFF_TXBUF);
  wire wr_ie    = wr & (addr == SBIR_OFF_IE);
  wire wr_ifg   = wr & (addr == SBIR_OFF_IFG);
  wire rd_rx    = rd & (addr == SBIR_OFF_RXBUF);
  wire [1:0] pend = ifg_r & ie_r;
  // receive has priority over transmit
  wire [15:0] iv_code = pend[SBIR_BIT_RX] ? SBIR_IV_RX :
                        pend[SBIR_BIT_TX] ? SBIR_IV_TX : SBIR_IV_NONE; // R8
  wire [15:0] stat_w = {10'h000, oe_r, 4'h0, busy};

  sbir_sync #(.W(3)) u_sync (
    .clock (clock),
    .srst  (srst),
    .d     ({spi_sclk, spi_mosi, ~spi_ssel_n}),
    .q     (pins_q)
  );
  // select carried inverted so the flops clear to the deselected level
  assign link = '{sclk: pins_q[2], mosi: pins_q[1], ssel_n: ~pins_q[0]};

  sbir_shift u_shift (
    .clock    (clock),
    .srst     (rst_all),
    .link     (link),
    .seven    (seven),
    .tx_valid (tx_full_r),
    .tx_data  (txbuf_r),
    .tx_take  (tx_take),
    .rx_done  (rx_done),
    .rx_data  (rx_data),
    .busy     (busy),
    .miso     (spi_miso)
  );

  // control register is outside the software reset it drives
  always_ff @(posedge clock) begin
    if (srst) ctrl_r <= SBIR_CTRL_RST;
    else if (wr_ctrl) ctrl_r <= wdata[1:0];
  end

  always_ff @(posedge clock) begin
    if (rst_all) begin
      rxbuf_r <= 8'h00;
      rx_unread_r <= 1'b0;
    end else if (rx_done) begin
      rxbuf_r <= sbir_mask7(rx_data, seven); // R1 R3
      rx_unread_r <= 1'b1;
    end else if (rd_rx) begin
      rx_unread_r <= 1'b0;
    end
  end

  // overrun: a clearing read in the same cycle wins over the set
  always_ff @(posedge clock) begin
    if (rst_all) oe_r <= 1'b0;
    else if (rx_done & rx_unread_r & ~rd_rx) oe_r <= 1'b1; // R9
    else if (rd_rx) oe_r <= 1'b0; // R2 R9
  end

  always_ff @(posedge clock) begin
    if (rst_all) begin
      txbuf_r   <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (wr_tx) begin
      txbuf_r   <= sbir_mask7(wdata[7:0], seven); // R4 R5
      tx_full_r <= 1'b1;
    end else if (tx_take) begin
      tx_full_r <= 1'b0; // R4
    end
  end

  always_ff @(posedge clock) begin
    if (rst_all) ie_r <= 2'h0;
    else if (wr_ie) ie_r <= wdata[1:0];
  end

  // flags: receive set wins over read or software clear; transmit-buffer write clear wins over take set
  always_ff @(posedge clock) begin
    if (rst_all) begin
      ifg_r <= SBIR_IFG_RST; // R6 R7
    end else begin
      if (rx_done) ifg_r[SBIR_BIT_RX] <= 1'b1; // R7
      else if (rd_rx) ifg_r[SBIR_BIT_RX] <= 1'b0; // R2
      else if (wr_ifg) ifg_r[SBIR_BIT_RX] <= wdata[SBIR_BIT_RX];
      // a refill in the take cycle leaves the buffer full, so no flag
      if (wr_tx) ifg_r[SBIR_BIT_TX] <= 1'b0; // R4
      else if (tx_take) ifg_r[SBIR_BIT_TX] <= 1'b1; // R6
      else if (wr_ifg) ifg_r[SBIR_BIT_TX] <= wdata[SBIR_BIT_TX];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rdata <= 16'h0000;
      irq   <= 1'b0;
    end else begin
      irq <= |pend; // R10
      if (rd) begin
        case (addr)
          SBIR_OFF_RXBUF: rdata <= {8'h00, rxbuf_r}; // R1
          SBIR_OFF_TXBUF: rdata <= {8'h00, txbuf_r};
          SBIR_OFF_CTRL:  rdata <= {14'h0000, ctrl_r};
          SBIR_OFF_STAT:  rdata <= stat_w;
          SBIR_OFF_IE:    rdata <= {14'h0000, ie_r};
          SBIR_OFF_IFG:   rdata <= {14'h0000, ifg_r};
          SBIR_OFF_IV:    rdata <= iv_code; // R8
          default:        rdata <= 16'h0000;
        endcase
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  AST_RX_CLEAR: assert property (@(posedge clock) disable iff (rst_all)
    rd_rx & ~rx_done |=> ~ifg_r[SBIR_BIT_RX] & ~oe_r) // R2
    else $error("receive read did not clear flags");
  AST_RX_SET: assert property (@(posedge clock) disable iff (rst_all)
    rx_done |=> ifg_r[SBIR_BIT_RX] && rxbuf_r == sbir_mask7($past(rx_data), seven)) // R7
    else $error("receive flag or data missing");
  AST_RX_TOP: assert property (@(posedge clock) disable iff (rst_all)
    seven & rx_done |=> ~rxbuf_r[7]) // R3
    else $error("seven-bit receive top bit set");
  AST_TX_WR: assert property (@(posedge clock) disable iff (rst_all)
    wr_tx |=> ~ifg_r[SBIR_BIT_TX] && tx_full_r) // R4
    else $error("transmit write did not clear flag");
  AST_TX_TOP: assert property (@(posedge clock) disable iff (rst_all)
    wr_tx & seven |=> ~txbuf_r[7]) // R5
    else $error("seven-bit transmit top bit set");
  AST_TX_EMPTY: assert property (@(posedge clock) disable iff (rst_all)
    tx_take & ~wr_tx |=> ifg_r[SBIR_BIT_TX]) // R6
    else $error("transmit flag not set on empty");
  AST_OVR: assert property (@(posedge clock) disable iff (rst_all)
    rx_unread_r & rx_done & ~rd_rx |=> oe_r) // R9
    else $error("overrun not flagged");
  AST_IV: assert property (@(posedge clock) disable iff (rst_all)
    pend[SBIR_BIT_RX] |-> iv_code == SBIR_IV_RX) // R8
    else $error("vector priority wrong");
  AST_IRQ: assert property (@(posedge clock) disable iff (rst_all)
    ##1 irq == |$past(pend)) // R10
    else $error("interrupt output mismatch");
  AST_RST: assert property (@(posedge clock)
    srst |=> ifg_r == SBIR_IFG_RST) // R6
    else $error("flag reset value wrong");
  COV_RX: cover property (@(posedge clock) disable iff (rst_all) rx_done ##[1:50] rd_rx);
  COV_OVR: cover property (@(posedge clock) disable iff (rst_all) $rose(oe_r));
  COV_TX: cover property (@(posedge clock) disable iff (rst_all) wr_tx ##[1:200] tx_take);
endmodule
`default_nettype wire

// ===== tb_sbir_top.sv
// Purpose: self-checking bench for the buffer and interrupt block
// Assumes: partner master drives the link pins
// Notes:   random bytes from a fixed-seed xorshift
`default_nettype none
module tb_sbir_top;
  import sbir_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        srst;
  logic        wr;
  logic        rd;
  logic [8:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        spi_sclk;
  logic        spi_mosi;
  logic        spi_ssel_n;
  logic        spi_miso;
  logic        irq;
  logic [31:0] seed = 32'h0cb0_8028;
  int          error_cnt = 0;
  int          checked = 0;

  sbir_top u_sbir_top (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_ssel_n(spi_ssel_n),
    .spi_miso(spi_miso), .irq(irq));
  sbir_spi_master u_sbir_spi_master (.sclk(spi_sclk), .mosi(spi_mosi), .ssel_n(spi_ssel_n),
    .miso(spi_miso));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [15:0] m7(input logic [7:0] d, input logic s);
    return {8'h00, s ? {1'b0, d[6:0]} : d};
  endfunction

  task automatic end_sim;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [8:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [8:0] a, output logic [15:0] q);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    q = rdata;
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [15:0] exp);
    logic [15:0] q;
    rd_reg(a, q);
    chk(q, exp);
  endtask
  // polls the flags only, so the receive flag is not disturbed
  task automatic wait_rx;
    logic [15:0] q;
    for (int n = 0; n < 40; n++) begin
      rd_reg(SBIR_OFF_IFG, q);
      if (q[0] === 1'b1) return;
    end
    error_cnt++;
    end_sim;
  endtask
  task automatic xfer_chk(input logic [7:0] tx, input logic [7:0] mo, input logic s);
    logic [7:0] got;
    wr_reg(SBIR_OFF_TXBUF, {8'h00, tx});
    rd_chk(SBIR_OFF_TXBUF, m7(tx, s));
    u_sbir_spi_master.xfer(mo, s ? 7 : 8, got);
    wait_rx;
    chk({8'h00, got}, m7(tx, s));
  endtask

  initial begin
    #400_000;
    error_cnt++;
    end_sim;
  end

  initial begin
    logic [7:0] tx;
    logic [7:0] mo;
    logic       s;
    srst = 1'b1;
    addr = 9'h000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rd_chk(SBIR_OFF_RXBUF, 16'h0000);
    rd_chk(SBIR_OFF_TXBUF, 16'h0000);
    rd_chk(SBIR_OFF_IE, 16'h0000);
    rd_chk(SBIR_OFF_IFG, 16'h0002);
    rd_chk(SBIR_OFF_IV, SBIR_IV_NONE);
    rd_chk(9'h100, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      s = i[0];
      tx = rnd8();
      mo = rnd8();
      wr_reg(SBIR_OFF_CTRL, {14'h0000, s, 1'b0});
      wr_reg(SBIR_OFF_IE, 16'h0003);
      wr_reg(SBIR_OFF_TXBUF, {8'h00, tx});
      rd_chk(SBIR_OFF_IFG, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      xfer_chk(tx, mo, s);
      rd_chk(SBIR_OFF_IFG, 16'h0003);
      rd_chk(SBIR_OFF_IV, SBIR_IV_RX);
      chk({15'h0000, irq}, 16'h0001);
      rd_chk(SBIR_OFF_RXBUF, m7(mo, s));
      rd_chk(SBIR_OFF_IFG, 16'h0002);
      rd_chk(SBIR_OFF_IV, SBIR_IV_TX);
      wr_reg(SBIR_OFF_IE, 16'h0000);
      rd_chk(SBIR_OFF_IV, SBIR_IV_NONE);
      chk({15'h0000, irq}, 16'h0000);
    end
    $display("test transfers done");
    wr_reg(SBIR_OFF_CTRL, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      mo = rnd8();
      xfer_chk(rnd8(), mo, 1'b0);
    end
    rd_chk(SBIR_OFF_STAT, 16'h0020);
    rd_chk(SBIR_OFF_RXBUF, {8'h00, mo});
    rd_chk(SBIR_OFF_STAT, 16'h0000);
    $display("test overrun done");
    wr_reg(SBIR_OFF_IFG, 16'h0000);
    wr_reg(SBIR_OFF_IE, 16'h0002);
    rd_chk(SBIR_OFF_IV, SBIR_IV_NONE);
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(SBIR_OFF_IFG, 16'h0002);
    rd_chk(SBIR_OFF_IV, SBIR_IV_TX);
    chk({15'h0000, irq}, 16'h0001);
    $display("test flag write done");
    end_sim;
  end
endmodule
`default_nettype wire
